/* verilog/mmei_top.sv */
// Purpose: Position line interface: quadrature in, step/direction, RC servo, quadrature out
// Assumes: motor_position comes from logic on clk; lines are asynchronous pins
// Notes:   Register port data is 16 bits, read data valid one cycle after the strobe
module mmei_top
    import mmei_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        phase_a_line_in,
    input  wire logic        phase_b_line_in,
    output logic             phase_a_line_out,
    output logic             phase_a_line_oe,
    output logic             phase_b_line_out,
    output logic             phase_b_line_oe,
    output logic             bias_pullup,
    input  wire logic [31:0] motor_position,
    output logic      [31:0] setpoint
);
    typedef enum logic [1:0] {
        MMEI_RC_IDLE = 2'b01,
        MMEI_RC_HIGH = 2'b10
    } mmei_rc_e;

    logic [15:0]         config_r;
    logic [15:0]         scale_r;
    logic [31:0]         count_r;
    logic                a_f;
    logic                b_f;
    logic                a_prev_r;
    logic                b_prev_r;
    logic [3:0]          mode;
    logic [2:0]          filter;
    logic                dir_flag;
    logic                quad_step;
    logic                quad_up;
    logic                step_fall;
    logic                step_up;
    mmei_rc_e            rc_state_r;
    logic [RC_CNT_W-1:0] rc_len_r;
    logic                rc_done;
    logic [15:0]         rc_value;
    logic [31:0]         out_pos_r;
    logic [7:0]          out_wait_r;
    logic [1:0]          out_idx;
    logic [47:0]         scaled;

    // Signed saturation of a pulse length offset to 16 bits
    function automatic logic [15:0] sat16(input logic [RC_CNT_W:0] v);
        if ($signed(v) > $signed(21'sh007FFF)) begin
            sat16 = 16'h7FFF;
        end else if ($signed(v) < $signed(-21'sh008000)) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // Config fields
    assign mode     = config_r[CFG_MODE_LSB +: 4];
    assign filter   = config_r[CFG_FILT_LSB +: 3];
    assign dir_flag = config_r[CFG_DIR_BIT];

    // Input conditioning, one filter per line
    mmei_line_filter u_filt_a (
        .clk    (clk),
        .srst   (srst),
        .pin    (phase_a_line_in),
        .filter (filter),
        .level  (a_f)
    );
    mmei_line_filter u_filt_b (
        .clk    (clk),
        .srst   (srst),
        .pin    (phase_b_line_in),
        .filter (filter),
        .level  (b_f)
    );

    // Previous filtered levels for edge and phase detection
    always_ff @(posedge clk) begin
        if (srst) begin
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
        end else begin
            a_prev_r <= a_f;
            b_prev_r <= b_f;
        end
    end

    // Quadrature decode: one count per single-line change
    assign quad_step = (a_f ^ a_prev_r) ^ (b_f ^ b_prev_r);
    assign quad_up   = (a_f ^ b_prev_r) ^ dir_flag;
    // Step on falling edge of line A, direction from line B
    assign step_fall = a_prev_r & ~a_f;
    assign step_up   = b_f ^ dir_flag;

    // RC pulse length measurement on line A
    always_ff @(posedge clk) begin
        if (srst || mode != MODE_RC_SERVO) begin
            rc_state_r <= MMEI_RC_IDLE;
            rc_len_r   <= '0;
        end else begin
            case (rc_state_r)
                MMEI_RC_IDLE: begin
                    rc_len_r <= '0;
                    if (a_f && !a_prev_r) begin
                        rc_state_r <= MMEI_RC_HIGH;
                    end
                end
                MMEI_RC_HIGH: begin
                    if (!a_f) begin
                        rc_state_r <= MMEI_RC_IDLE;
                    end else if (rc_len_r != RC_CNT_W'(RC_MAX_CYC)) begin
                        rc_len_r <= rc_len_r + 1'b1;
                    end
                end
                default: rc_state_r <= MMEI_RC_IDLE;
            endcase
        end
    end

    assign rc_done  = (rc_state_r == MMEI_RC_HIGH) && !a_f;
    assign rc_value = sat16({1'b0, rc_len_r} - (RC_CNT_W + 1)'(RC_CENTER_CYC));

    // Position count: software load wins, then the active mode updates it
    always_ff @(posedge clk) begin
        if (srst) begin
            count_r <= '0;
        end else if (reg_wr && reg_addr == ADDR_COUNT_LO) begin
            count_r[15:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == ADDR_COUNT_HI) begin
            count_r[31:16] <= reg_wdata;
        end else begin
            case (mode)
                MODE_QUAD_IN: begin
                    if (quad_step) begin
                        count_r <= quad_up ? count_r + 32'h1 : count_r - 32'h1;
                    end
                end
                MODE_STEP_DIR: begin
                    if (step_fall) begin
                        count_r <= step_up ? count_r + 32'h1 : count_r - 32'h1;
                    end
                end
                MODE_RC_SERVO: begin
                    if (rc_done) begin
                        count_r <= {{16{rc_value[15]}}, rc_value};
                    end
                end
                default: count_r <= count_r;
            endcase
        end
    end

    // Config and scale registers; count is not touched by config writes
    always_ff @(posedge clk) begin
        if (srst) begin
            config_r <= CONFIG_RESET;
            scale_r  <= SCALE_RESET;
        end else if (reg_wr && reg_addr == ADDR_CONFIG) begin
            config_r <= reg_wdata & CONFIG_MASK;
        end else if (reg_wr && reg_addr == ADDR_SCALE) begin
            scale_r <= reg_wdata;
        end
    end

    // Read port, data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CONFIG:   reg_rdata <= config_r;
                ADDR_COUNT_LO: reg_rdata <= count_r[15:0];
                ADDR_COUNT_HI: reg_rdata <= count_r[31:16];
                ADDR_SCALE:    reg_rdata <= scale_r;
                default:       reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Scaled setpoint for the loop controller, signed gain in 8.8 form
    assign scaled = 48'($signed(count_r) * $signed(scale_r));
    always_ff @(posedge clk) begin
        if (srst) begin
            setpoint <= '0;
        end else begin
            setpoint <= scaled[SCALE_SHIFT +: 32];
        end
    end

    // Output tracker: one quadrature state per filter time toward motor position
    always_ff @(posedge clk) begin
        if (srst) begin
            out_pos_r  <= '0;
            out_wait_r <= '0;
        end else if (mode != MODE_QUAD_OUT) begin
            out_pos_r  <= motor_position;
            out_wait_r <= '0;
        end else if (out_wait_r != 8'h00) begin
            out_wait_r <= out_wait_r - 8'h01;
        end else if (out_pos_r != motor_position) begin
            out_wait_r <= (FILT_BASE_CYC << filter) - 8'h01;
            if ($signed(motor_position - out_pos_r) > 0) begin
                out_pos_r <= out_pos_r + 32'h1;
            end else begin
                out_pos_r <= out_pos_r - 32'h1;
            end
        end
    end

    assign out_idx = out_pos_r[1:0];

    // Line drivers and bias select, all registered
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_a_line_out <= 1'b0;
            phase_b_line_out <= 1'b0;
            phase_a_line_oe  <= 1'b0;
            phase_b_line_oe  <= 1'b0;
            bias_pullup      <= 1'b0;
        end else begin
            phase_a_line_out <= dir_flag ? out_idx[1] : out_idx[1] ^ out_idx[0];
            phase_b_line_out <= dir_flag ? out_idx[1] ^ out_idx[0] : out_idx[1];
            phase_a_line_oe  <= (mode == MODE_QUAD_OUT);
            phase_b_line_oe  <= (mode == MODE_QUAD_OUT);
            bias_pullup      <= config_r[CFG_BIAS_BIT];
        end
    end
endmodule : mmei_top

/* verilog/mmei_pkg.sv */
// Purpose: Constants for the multi-mode position line interface
// Assumes: 125 MHz clock, 16-bit register port with 8-bit address
// Notes:   Offsets are register numbers as seen on the register port
// Notes on behaviour
// - Quadrature mode decodes two lines a quarter period apart into movement and direction.
// - Quadrature decode handles pulse rates to 2.2 MHz, limited by the filter setting.
// - Count changes on every phase transition, four counts per input period.
// - Scaled position count is offered as a setpoint source for the loop controller.
// - Step/direction mode moves the count by one per complete step pulse.
// - RC servo mode measures pulse length and stores a signed 16-bit result.
// - Output mode drives both lines as a quadrature pair tracking motor position.
// - Config holds mode 3:0, filter 6:4, direction bit 8, bias select bit 9.
// - Mode codes: 0 off, 1 quadrature in, 2 step/direction, 4 RC servo, 8 quadrature out.
// - Filter 0 to 7, 0 fastest near 10 MHz, each step halves; resets to 4.
// - Direction 0 means A leading B is positive; 1 means B leading A.
// - Count is readable and writable and survives config rewrites.
package mmei_pkg;
    localparam logic [7:0]  ADDR_CONFIG   = 8'hB4;   // 180
    localparam logic [7:0]  ADDR_COUNT_LO = 8'hB8;   // 184
    localparam logic [7:0]  ADDR_COUNT_HI = 8'hB9;   // 185
    localparam logic [7:0]  ADDR_SCALE    = 8'hBA;   // 186
    localparam int          CFG_MODE_LSB  = 0;
    localparam int          CFG_FILT_LSB  = 4;
    localparam int          CFG_DIR_BIT   = 8;
    localparam int          CFG_BIAS_BIT  = 9;
    localparam logic [15:0] CONFIG_RESET  = 16'h0040;
    localparam logic [15:0] CONFIG_MASK   = 16'h03FF;
    localparam logic [15:0] SCALE_RESET   = 16'h0100;
    localparam int          SCALE_SHIFT   = 8;
    localparam logic [3:0]  MODE_OFF      = 4'h0;
    localparam logic [3:0]  MODE_QUAD_IN  = 4'h1;
    localparam logic [3:0]  MODE_STEP_DIR = 4'h2;
    localparam logic [3:0]  MODE_RC_SERVO = 4'h4;
    localparam logic [3:0]  MODE_QUAD_OUT = 4'h8;
    localparam int          CLK_MHZ       = 125;
    localparam int          RC_CENTER_US  = 1500;
    localparam int          RC_CENTER_CYC = RC_CENTER_US * CLK_MHZ;
    localparam int          RC_MAX_US     = 3000;
    localparam int          RC_MAX_CYC    = RC_MAX_US * CLK_MHZ;
    localparam int          RC_CNT_W      = 20;
    localparam int          FILT_CNT_W    = 8;
    localparam logic [7:0]  FILT_BASE_CYC = 8'h01;
endpackage : mmei_pkg

/* verilog/mmei_line_filter.sv */
// Purpose: Synchronise one pin and pass a level only after it is stable
// Assumes: Pin is asynchronous to clk
// Notes:   Hold time is 2**filter cycles, so each filter step halves the rate
module mmei_line_filter
    import mmei_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       pin,
    input  wire logic [2:0] filter,
    output logic            level
);
    logic                  sync1_r;
    logic                  sync2_r;
    logic [FILT_CNT_W-1:0] stable_r;
    logic [FILT_CNT_W-1:0] limit;

    // Two-stage synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
        end
    end

    assign limit = FILT_BASE_CYC << filter;

    // Accept a new level once stable for the filter time
    always_ff @(posedge clk) begin
        if (srst) begin
            stable_r <= '0;
            level    <= 1'b0;
        end else if (sync2_r == level) begin
            stable_r <= '0;
        end else if (stable_r + 8'h01 >= limit) begin
            stable_r <= '0;
            level    <= sync2_r;
        end else begin
            stable_r <= stable_r + 8'h01;
        end
    end
endmodule : mmei_line_filter

/* tb/mmei_checker.sv */
// Purpose: Port assertions for mmei_top
// Assumes: One clock, srst synchronous
// Notes:   Bound to every mmei_top
module mmei_checker
    import mmei_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        phase_a_line_out,
    input wire logic        phase_a_line_oe,
    input wire logic        phase_b_line_out,
    input wire logic        phase_b_line_oe,
    input wire logic        bias_pullup
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Config write, then two quiet cycles
    sequence s_cfg_wr;
        reg_wr && reg_addr == ADDR_CONFIG;
    endsequence
    sequence s_quiet2;
        !reg_wr [*2];
    endsequence
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    property p_cfg_rb;
        s_cfg_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == ADDR_CONFIG)
            |=> reg_rdata == ($past(reg_wdata, 3) & CONFIG_MASK);
    endproperty
    property p_unmap;
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == 16'h0000;
    endproperty
    property p_oe_on;
        s_cfg_wr ##0 reg_wdata[3:0] == MODE_QUAD_OUT ##1 s_quiet2 |-> phase_a_line_oe;
    endproperty
    property p_oe_off;
        s_cfg_wr ##0 reg_wdata[3:0] != MODE_QUAD_OUT ##1 s_quiet2 |-> !phase_a_line_oe;
    endproperty
    property p_bias;
        s_cfg_wr ##1 s_quiet2 |-> bias_pullup == $past(reg_wdata[9], 2);
    endproperty
    property p_oe_pair;
        phase_a_line_oe == phase_b_line_oe;
    endproperty
    property p_gray;
        phase_a_line_oe && $past(phase_a_line_oe) |-> !($changed(phase_a_line_out) && $changed(phase_b_line_out));
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_oe_on: assert property (p_oe_on) else $error("output enable missing");
    a_oe_off: assert property (p_oe_off) else $error("output enable stray");
    a_bias: assert property (p_bias) else $error("bias select wrong");
    a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
    a_gray: assert property (p_gray) else $error("both output lines moved");
endmodule : mmei_checker

bind mmei_top mmei_checker u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_a_line_out(phase_a_line_out),
    .phase_a_line_oe(phase_a_line_oe), .phase_b_line_out(phase_b_line_out),
    .phase_b_line_oe(phase_b_line_oe), .bias_pullup(bias_pullup));

/* tb/mmei_partner.sv */
// Purpose: Far side: encoder, step controller or servo transmitter
// Assumes: Device samples lines through its filter
// Notes:   hold is set by the bench from the filter value
module mmei_partner
    import mmei_pkg::*;
(
    input  wire logic clk,
    output logic      line_a,
    output logic      line_b
);
    int hold = 24;
    initial begin
        line_a = 1'b0;
        line_b = 1'b0;
    end
    // Wait out the device filter
    task automatic rest;
        repeat (hold) @(posedge clk);
    endtask : rest
    // One phase step, fwd means A leads B
    task automatic quad(input bit fwd);
        @(posedge clk);
        if (fwd)
            {line_a, line_b} <= {~line_b, line_a};
        else
            {line_a, line_b} <= {line_b, ~line_a};
        rest();
    endtask : quad
    // Both lines flip at once, a fault
    task automatic both;
        @(posedge clk);
        {line_a, line_b} <= ~{line_a, line_b};
        rest();
    endtask : both
    // Both lines low
    task automatic idle;
        @(posedge clk);
        {line_a, line_b} <= 2'b00;
        rest();
    endtask : idle
    // Step pulse; direction settles while step is high
    task automatic step(input bit up);
        @(posedge clk);
        {line_a, line_b} <= {1'b1, ~up};
        rest();
        line_b <= up;
        rest();
        line_a <= 1'b0;
        rest();
    endtask : step
    // Servo pulse of len cycles on line A
    task automatic pulse(input int len);
        @(posedge clk);
        line_a <= 1'b1;
        repeat (len) @(posedge clk);
        line_a <= 1'b0;
        rest();
    endtask : pulse
endmodule : mmei_partner

/* tb/mmei_top_tb.sv */
// Purpose: Self-checking bench for mmei_top
// Assumes: 125 MHz clock, partner drives lines unless device drives
// Notes:   Count model kept in mcount
module mmei_top_tb
    import mmei_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pa, pb, ao, ae, bo, be, bias;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, r;
    logic [31:0] mpos = 32'h0, setpoint, got;
    int          num_errors = 0, tests_run = 0, mcount, f;
    bit          up;
    // Clock
    always #4 clk = ~clk;
    mmei_partner pm (.clk(clk), .line_a(pa), .line_b(pb));
    mmei_top uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_a_line_in(ae ? ao : pa), .phase_b_line_in(be ? bo : pb),
        .phase_a_line_out(ao), .phase_a_line_oe(ae), .phase_b_line_out(bo), .phase_b_line_oe(be),
        .bias_pullup(bias), .motor_position(mpos), .setpoint(setpoint));
    task automatic chk_reg(input logic [15:0] g, e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_reg
    task automatic chk_cnt(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_cnt
    task automatic conclude;
        $display("compares %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic rdcnt(output logic [31:0] v);
        rd(ADDR_COUNT_LO, v[15:0]);
        rd(ADDR_COUNT_HI, v[31:16]);
    endtask : rdcnt
    // Idle lines, then new mode with zero count
    task automatic mode(input logic [3:0] m, input logic [2:0] fl, input logic d);
        wr(ADDR_CONFIG, 16'h0000);
        pm.idle();
        wr(ADDR_CONFIG, {7'h00, d, 1'b0, fl, m});
        pm.hold = (1 << fl) + 8;
        @(posedge clk);
        wr(ADDR_COUNT_LO, 16'h0000);
        wr(ADDR_COUNT_HI, 16'h0000);
        mcount = 0;
    endtask : mode
    // Watchdog
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        f = $urandom(32'h072fa923);
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(ADDR_CONFIG, r);
        chk_reg(r, CONFIG_RESET);
        rd(8'h00, r);
        chk_reg(r, 16'h0000);
        wr(ADDR_CONFIG, 16'hFFFF);
        rd(ADDR_CONFIG, r);
        chk_reg(r, CONFIG_MASK);
        chk_reg({15'h0, bias}, 16'h0001);
        wr(ADDR_COUNT_LO, 16'hBEEF);
        wr(ADDR_COUNT_HI, 16'h8001);
        wr(ADDR_CONFIG, 16'h0020);
        rdcnt(got);
        chk_cnt(got, 32'h8001BEEF);
        wr(ADDR_COUNT_HI, 16'h0000);
        wr(ADDR_COUNT_LO, 16'h1000);
        wr(ADDR_SCALE, 16'h0180);
        @(posedge clk);
        chk_cnt(setpoint, 32'h00001800);
        wr(ADDR_SCALE, SCALE_RESET);
        $display("registers done");
        for (int d = 0; d < 2; d++) begin
            mode(MODE_QUAD_IN, 3'($urandom % 8), d[0]);
            for (int i = 0; i < 12; i++) begin
                up = ($urandom % 3) != 0;
                pm.quad(up);
                mcount += (up ^ d[0]) ? 1 : -1;
            end
            pm.both();
            rdcnt(got);
            chk_cnt(got, mcount);
            mode(MODE_STEP_DIR, 3'h1, d[0]);
            for (int i = 0; i < 10; i++) begin
                up = $urandom % 2;
                pm.step(up);
                mcount += (up ^ d[0]) ? 1 : -1;
            end
            rdcnt(got);
            chk_cnt(got, mcount);
            mpos <= 32'h0;
            mode(MODE_QUAD_OUT, 3'h0, d[0]);
            mpos <= 32'h3;
            repeat (30) @(posedge clk);
            chk_reg({14'h0, ao, bo}, d ? 16'h0002 : 16'h0001);
        end
        $display("line modes done");
        mode(MODE_RC_SERVO, 3'h0, 1'b0);
        pm.pulse(200 + $urandom % 300);
        rdcnt(got);
        chk_cnt(got, 32'hFFFF8000);
        $display("servo done");
        conclude();
    end
endmodule : mmei_top_tb
